// ---- dpo_pkg.sv ----
package dpo_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register addresses on the module register port
   localparam logic [7:0] DPO_PWR_ADDR = 8'h31;
   localparam logic [7:0] DPO_DATA_ADDR = 8'h50;
   localparam logic [7:0] DPO_CFG_ADDR = 8'h51;
   localparam logic [7:0] DPO_STAT_ADDR = 8'h52;

   // power-on control register bit positions
   localparam int DPO_PWR_DAC_BIT = 0;
   localparam int DPO_PWR_AMP_BIT = 1;

   // configuration register bit positions
   localparam int DPO_CFG_DAC_EN = 0;
   localparam int DPO_CFG_DAC_LARGE = 1;
   localparam int DPO_CFG_PWM_EN = 2;
   localparam int DPO_CFG_AMP_EN = 3;
   localparam int DPO_CFG_AMP_BUF = 4;
   localparam int DPO_CFG_REF_EXT = 5;

   // status register field positions
   localparam int DPO_STAT_PWM_BIT = 0;
   localparam int DPO_STAT_DUTY_LSB = 4;

   // reset values
   localparam logic [15:0] DPO_PWR_RST = 16'h0000;
   localparam logic [15:0] DPO_DATA_RST = 16'h0000;
   localparam logic [15:0] DPO_CFG_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int DPO_CLK_MHZ = 100;
   localparam int DPO_PWM_STEP_NS = 2000;
   localparam int DPO_PWM_STEP_CYC = (DPO_PWM_STEP_NS * DPO_CLK_MHZ) / 1000;
   localparam int DPO_PWM_BITS = 12;
   localparam logic [11:0] DPO_PWM_LAST_STEP = 12'hFFF;
   localparam logic [11:0] DPO_PWM_SIGN = 12'h800;

   ////////////////////////////////////////////////////////////////////////
   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } dpo_req_s;

   // switch and power settings driven to the analog section
   typedef struct packed {
      logic dac_on;
      logic dac_ref_ext;
      logic dac_to_large;
      logic dac_to_small;
      logic large_amp_on;
      logic small_amp_on;
      logic large_fb_int;
      logic small_fb_int;
      logic large_inv_hiz;
      logic small_inv_hiz;
      logic pwm_to_large;
      logic pwm_to_small;
   } dpo_route_s;

   // pwm core state
   typedef struct packed {
      logic [15:0] pre;
      logic [11:0] step;
      logic [11:0] duty;
      logic pwm;
      logic period_end;
   } dpo_pwm_st_s;

endpackage : dpo_pkg

// ---- dpo_pwm.sv ----
`timescale 1ns/1ns
module dpo_pwm
   import dpo_pkg::*;
#(
   parameter int STEP_CYC = DPO_PWM_STEP_CYC
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_en,
   input wire logic [11:0] i_code,
   output logic o_pwm,
   output logic o_period_end,
   output logic [11:0] o_duty
);

   initial
   begin
      if (STEP_CYC < 1 || STEP_CYC > 65536)
         $error("dpo_pwm: STEP_CYC out of range");
   end

   localparam logic [15:0] PRE_LAST = 16'(STEP_CYC - 1);

   dpo_pwm_st_s st_ff;
   dpo_pwm_st_s nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // step prescaler, period counter, duty reload and compare
   always_comb
   begin
      logic tick;
      tick = 1'b0;
      nxt_st = st_ff;
      nxt_st.period_end = 1'b0;
      if (!i_en)
      begin
         nxt_st.pre = '0;
         nxt_st.step = '0;
         nxt_st.duty = i_code ^ DPO_PWM_SIGN;
      end
      else
      begin
         tick = (st_ff.pre == PRE_LAST);
         nxt_st.pre = tick ? 16'h0000 : st_ff.pre + 16'h0001;
         if (tick)
         begin
            nxt_st.step = st_ff.step + 12'h001;
            if (st_ff.step == DPO_PWM_LAST_STEP)
            begin
               // new duty only at the period boundary
               nxt_st.duty = i_code ^ DPO_PWM_SIGN;
               nxt_st.period_end = 1'b1;
            end
         end
      end
      // offset-binary duty: 0x800 gives 0 high steps, 0x7FF gives 4095
      nxt_st.pwm = i_en && (nxt_st.step < nxt_st.duty);
   end

   // state register
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign o_pwm = st_ff.pwm;
   assign o_period_end = st_ff.period_end;
   assign o_duty = st_ff.duty;

endmodule : dpo_pwm

// ---- dpo_output_module.sv ----
// How it works
// - pwm code is data word upper twelve bits
// - code zero gives half duty cycle
// - 0x800 zero high, 0x7FF 4095 high steps
// - period is 4096 steps, 8.192 ms
// - each step lasts 2 us
// - new duty loads at period end while pwm runs, every clock while off
// - dac takes whole word as signed
// - dac reference select, external doubled
// - power bits at 0x31 gate dac, amps
// - dac on large amp, pwm on small
// - dac on small amp, pwm on large
// - fixed priority prevents conflicting switches
// - at most two of three functions active
// - buffer mode: internal feedback, inverting pin hiz
// - power bits clear after reset
`timescale 1ns/1ns
module dpo_output_module
   import dpo_pkg::*;
#(
   parameter int STEP_CYC = DPO_PWM_STEP_CYC
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic [15:0] o_dac_code,
   output dpo_route_s o_route,
   output logic o_small_pin_out,
   output logic o_small_pin_oe,
   output logic o_large_pin_out,
   output logic o_large_pin_oe
);

   initial
   begin
      if (STEP_CYC < 1)
         $error("dpo_output_module: STEP_CYC must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // module state
   typedef struct packed {
      logic [15:0] pwr;
      logic [15:0] data;
      logic [15:0] cfg;
      logic [15:0] rdata;
      dpo_route_s route;
      logic small_out;
      logic small_oe;
      logic large_out;
      logic large_oe;
   } dpo_state_s;

   dpo_state_s st_ff;
   dpo_state_s nxt_st;
   dpo_req_s req;
   logic pwm_level;
   logic [11:0] pwm_duty;
   logic pwm_en;

   ////////////////////////////////////////////////////////////////////////
   // switch resolution: dac first, then pwm, then uncommitted amp
   function automatic dpo_route_s resolve(input logic [15:0] pwr,
                                          input logic [15:0] cfg);
      dpo_route_s r;
      logic amp_pw;
      logic dac;
      logic dac_lg;
      logic dac_sm;
      logic pwm;
      logic amp;
      logic amp_lg;
      logic amp_sm;
      logic buf_md;
      r = '0;
      amp_pw = pwr[DPO_PWR_AMP_BIT];
      dac = cfg[DPO_CFG_DAC_EN] & pwr[DPO_PWR_DAC_BIT];
      dac_lg = dac & amp_pw & cfg[DPO_CFG_DAC_LARGE];
      dac_sm = dac & amp_pw & ~cfg[DPO_CFG_DAC_LARGE];
      pwm = cfg[DPO_CFG_PWM_EN];
      // only two pins: the amp loses when dac and pwm both run
      amp = cfg[DPO_CFG_AMP_EN] & amp_pw & ~(dac & pwm);
      amp_lg = amp & ~dac_lg;
      amp_sm = amp & dac_lg;
      buf_md = cfg[DPO_CFG_AMP_BUF];
      r.dac_on = dac;
      r.dac_ref_ext = dac & cfg[DPO_CFG_REF_EXT];
      r.dac_to_large = dac_lg;
      r.dac_to_small = dac_sm;
      // pwm takes the pin the dac leaves free, small when no dac
      r.pwm_to_small = pwm & ~dac_sm;
      r.pwm_to_large = pwm & dac_sm;
      r.large_amp_on = (dac_lg | amp_lg) & ~r.pwm_to_large;
      r.small_amp_on = (dac_sm | amp_sm) & ~r.pwm_to_small;
      r.large_fb_int = r.large_amp_on & (dac_lg | buf_md);
      r.small_fb_int = r.small_amp_on & (dac_sm | buf_md);
      // inverting pin floats in buffer mode, when the dac drives the amp, or when the amp is off
      r.large_inv_hiz = ~r.large_amp_on | r.large_fb_int;
      r.small_inv_hiz = ~r.small_amp_on | r.small_fb_int;
      return r;
   endfunction : resolve

   ////////////////////////////////////////////////////////////////////////
   // request bundle
   always_comb
   begin
      req.wr = i_reg_wr;
      req.rd = i_reg_rd;
      req.addr = i_reg_addr;
      req.wdata = i_reg_wdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // pwm engine; runs only while its switch is closed
   assign pwm_en = st_ff.route.pwm_to_small | st_ff.route.pwm_to_large;

   dpo_pwm #(
      .STEP_CYC(STEP_CYC)
   ) u_pwm (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_en(pwm_en),
      .i_code(st_ff.data[15:4]),
      .o_pwm(pwm_level),
      .o_period_end(),
      .o_duty(pwm_duty)
   );

   ////////////////////////////////////////////////////////////////////////
   // register writes, read data, routing and pin drive
   always_comb
   begin
      nxt_st = st_ff;
      if (req.wr)
      begin
         case (req.addr)
            DPO_PWR_ADDR: nxt_st.pwr = req.wdata;
            DPO_DATA_ADDR: nxt_st.data = req.wdata;
            DPO_CFG_ADDR: nxt_st.cfg = req.wdata;
            default: nxt_st.pwr = st_ff.pwr;
         endcase
      end
      if (req.rd)
      begin
         case (req.addr)
            DPO_PWR_ADDR: nxt_st.rdata = st_ff.pwr;
            DPO_DATA_ADDR: nxt_st.rdata = st_ff.data;
            DPO_CFG_ADDR: nxt_st.rdata = st_ff.cfg;
            DPO_STAT_ADDR:
            begin
               nxt_st.rdata = '0;
               nxt_st.rdata[DPO_STAT_PWM_BIT] = pwm_level;
               nxt_st.rdata[DPO_STAT_DUTY_LSB +: 12] = pwm_duty;
            end
            default: nxt_st.rdata = 16'h0000;
         endcase
      end
      nxt_st.route = resolve(nxt_st.pwr, nxt_st.cfg);
      // pwm pin is driven only on the pin its switch selects
      nxt_st.small_oe = st_ff.route.pwm_to_small;
      nxt_st.small_out = st_ff.route.pwm_to_small & pwm_level;
      nxt_st.large_oe = st_ff.route.pwm_to_large;
      nxt_st.large_out = st_ff.route.pwm_to_large & pwm_level;
   end

   // state register; power bits come up cleared
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         st_ff <= '0;
         st_ff.pwr <= DPO_PWR_RST;
         // amps are off in reset, so both inverting pins float
         st_ff.route.large_inv_hiz <= 1'b1;
         st_ff.route.small_inv_hiz <= 1'b1;
         st_ff.data <= DPO_DATA_RST;
         st_ff.cfg <= DPO_CFG_RST;
      end
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; dac code is the full signed word, passed on at once
   assign o_reg_rdata = st_ff.rdata;
   assign o_dac_code = st_ff.data;
   assign o_route = st_ff.route;
   assign o_small_pin_out = st_ff.small_out;
   assign o_small_pin_oe = st_ff.small_oe;
   assign o_large_pin_out = st_ff.large_out;
   assign o_large_pin_oe = st_ff.large_oe;

endmodule : dpo_output_module

// ---- dpo_output_module_asserts.sv ----
`timescale 1ns/1ns
module dpo_output_module_asserts
   import dpo_pkg::*;
#(
   parameter int STEP_CYC = DPO_PWM_STEP_CYC
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic [15:0] o_dac_code,
   input wire dpo_route_s o_route,
   input wire logic o_small_pin_out,
   input wire logic o_small_pin_oe,
   input wire logic o_large_pin_out,
   input wire logic o_large_pin_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////
   // routing and data relations
   a_reset_all_off: assert property ($rose(i_rst_n) |->
      o_dac_code == 16'h0000 && !o_route.dac_on && !o_small_pin_oe)
      else $error("state not clear after reset");
   a_data_to_dac: assert property (
      i_reg_wr && i_reg_addr == DPO_DATA_ADDR |=> o_dac_code == $past(i_reg_wdata))
      else $error("dac code differs from written word");
   a_dac_one_amp: assert property (
      o_route.dac_on |-> o_route.dac_to_large ^ o_route.dac_to_small)
      else $error("dac not on exactly one amp");
   a_pwm_one_pin: assert property (
      !(o_route.pwm_to_large && o_route.pwm_to_small))
      else $error("pwm on both pins");
   a_pwm_large_free: assert property (
      o_route.pwm_to_large |-> !o_route.large_amp_on && !o_route.dac_to_large)
      else $error("large pin shared with pwm");
   a_pwm_small_free: assert property (
      o_route.pwm_to_small |-> !o_route.small_amp_on && !o_route.dac_to_small)
      else $error("small pin shared with pwm");
   a_buf_inv_hiz: assert property (
      o_route.large_fb_int |-> o_route.large_inv_hiz && o_route.large_amp_on)
      else $error("buffer mode without hiz inverting pin");
   a_pin_follows_route: assert property (
      $past(i_rst_n) |-> o_small_pin_oe == $past(o_route.pwm_to_small)
      && o_large_pin_oe == $past(o_route.pwm_to_large))
      else $error("pin drive does not follow route");
   a_two_funcs_max: assert property (
      o_route.dac_on && (o_route.pwm_to_large || o_route.pwm_to_small) |->
      !(o_route.large_amp_on && !o_route.dac_to_large)
      && !(o_route.small_amp_on && !o_route.dac_to_small))
      else $error("three functions active");
endmodule : dpo_output_module_asserts

bind dpo_output_module dpo_output_module_asserts #(.STEP_CYC(STEP_CYC)) i_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_dac_code(o_dac_code), .o_route(o_route),
   .o_small_pin_out(o_small_pin_out), .o_small_pin_oe(o_small_pin_oe),
   .o_large_pin_out(o_large_pin_out), .o_large_pin_oe(o_large_pin_oe));

// ---- dpo_load.sv ----
`timescale 1ns/1ns
module dpo_load
(
   input wire logic i_clk,
   input wire logic i_pin_out,
   input wire logic i_pin_oe,
   output logic o_level
);
   logic alt_ff = 1'b0;
   // an undriven pin shows a changing pattern, never a held value
   always_ff @(posedge i_clk)
   begin
      alt_ff <= !alt_ff;
   end
   assign o_level = i_pin_oe ? i_pin_out : alt_ff;
endmodule : dpo_load

// ---- tb_dpo_output_module.sv ----
`timescale 1ns/1ns
module tb_dpo_output_module;
   import dpo_pkg::*;
   localparam int PER = 8192;
   logic i_clk = 1'b0, i_rst_n = 1'b0, wr = 1'b0, rdr = 1'b0;
   logic [7:0] ad = 8'h00;
   logic [15:0] wd = 16'h0000, rdata, dac, rd, hi;
   dpo_route_s route;
   logic s_out, s_oe, l_out, l_oe, s_lvl, l_lvl;
   logic [55:0] rows [9];
   int fails = 0;
   int total_checks = 0;
   dpo_output_module #(.STEP_CYC(2)) i_dpo_output_module (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rdr), .i_reg_addr(ad),
      .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_dac_code(dac),
      .o_route(route), .o_small_pin_out(s_out), .o_small_pin_oe(s_oe),
      .o_large_pin_out(l_out), .o_large_pin_oe(l_oe));
   dpo_load i_dpo_load_s (.i_clk(i_clk), .i_pin_out(s_out),
      .i_pin_oe(s_oe), .o_level(s_lvl));
   dpo_load i_dpo_load_l (.i_clk(i_clk), .i_pin_out(l_out),
      .i_pin_oe(l_oe), .o_level(l_lvl));
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      #1;
      wr = w;
      rdr = !w;
      ad = a;
      wd = d;
      @(posedge i_clk);
      #1;
      wr = 1'b0;
      rdr = 1'b0;
      rd = rdata;
   endtask : acc
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic count_high(input logic lg);
      hi = 16'h0000;
      repeat (PER)
      begin
         @(posedge i_clk);
         #1;
         if ((lg ? l_lvl : s_lvl) === 1'b1)
            hi++;
      end
   endtask : count_high
   task automatic give_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   initial
   begin
      #900000;
      fails++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   // rows: power, config, route mask, expected route
   initial
   begin
      rows = '{{16'h3, 16'h03, 12'hB83, 12'hA80}, {16'h3, 16'h07, 12'hA43, 12'hA01},
         {16'h3, 16'h05, 12'h983, 12'h902}, {16'h0, 16'h01, 12'hB00, 12'h000},
         {16'h3, 16'h04, 12'h803, 12'h001}, {16'h3, 16'h21, 12'hC00, 12'hC00},
         {16'h3, 16'h0F, 12'hA43, 12'hA01}, {16'h3, 16'h0B, 12'h0FC, 12'h0E8},
         {16'h2, 16'h18, 12'h8A8, 12'h0A8}};
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      acc(1'b0, DPO_PWR_ADDR, 16'h0000);
      chk(rd, DPO_PWR_RST);
      chk({4'h0, route}, 16'h000C);
      acc(1'b0, 8'h00, 16'h0000);
      chk(rd, 16'h0000);
      acc(1'b1, DPO_DATA_ADDR, 16'h8001);
      chk(dac, 16'h8001);
      foreach (rows[i])
      begin
         acc(1'b1, DPO_PWR_ADDR, rows[i][55:40]);
         acc(1'b1, DPO_CFG_ADDR, rows[i][39:24]);
         repeat (2) @(posedge i_clk);
         #1;
         chk({4'h0, route & rows[i][23:12]}, {4'h0, rows[i][11:0]});
         acc(1'b0, DPO_CFG_ADDR, 16'h0000);
         chk(rd, rows[i][39:24]);
      end
      // pwm on small pin, low nibble ignored
      acc(1'b1, DPO_CFG_ADDR, 16'h0004);
      acc(1'b1, DPO_DATA_ADDR, 16'h000F);
      repeat (PER + 8) @(posedge i_clk);
      count_high(1'b0);
      chk(hi, 16'h1000);
      acc(1'b1, DPO_DATA_ADDR, 16'h7FF0);
      acc(1'b0, DPO_STAT_ADDR, 16'h0000);
      chk(rd & 16'hFFF0, 16'h8000);
      repeat (PER + 8) @(posedge i_clk);
      count_high(1'b0);
      chk(hi, 16'h1FFE);
      // pwm moves to large pin beside dac on small amp
      acc(1'b1, DPO_PWR_ADDR, 16'h0003);
      acc(1'b1, DPO_CFG_ADDR, 16'h0005);
      acc(1'b1, DPO_DATA_ADDR, 16'h8000);
      repeat (PER + 8) @(posedge i_clk);
      count_high(1'b1);
      chk(hi, 16'h0000);
      // second reset in mid-run
      @(posedge i_clk);
      #1;
      i_rst_n = 1'b0;
      @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      chk({4'h0, route}, 16'h000C);
      acc(1'b0, DPO_CFG_ADDR, 16'h0000);
      chk(rd, DPO_CFG_RST);
      give_verdict();
   end
endmodule : tb_dpo_output_module
